// >>> src/esmp_media_port.v
`timescale 1ns/1ps
`default_nettype none
`include "esmp_map.vh"
// Functional notes
// (RQ1) Ethernet mode: ring pair high/low static
// (RQ2) Transmit data changes on transmit clock
// (RQ3) Wrap output high requests loopback
// (RQ4) Front end runs transmit clock continuously
// (RQ5) Receive clock present with carrier
// (RQ6) Receive clock low while carrier idle
// (RQ7) Receive data sampled on receive clock
// (RQ8) Carrier sense frames the received bits
// (RQ9) Collision held two transmit clocks minimum
// (RQ10) Heartbeat pulse on collision is tolerated
// (RQ11) Transmit enable high exactly with data
// (RQ12) Ethernet only when selects low/high
// (RQ13) Selects change only during reset
// (RQ14) Crossings keep data and boundaries
module esmp_media_port (
  input  wire clk,
  input  wire rst,
  input  wire networkSelectOne,
  input  wire networkSelectTwo,
  input  wire txBitClock,
  input  wire rxBitClock,
  input  wire rxData,
  input  wire carrierSense,
  input  wire collisionDetect,
  input  wire frontEndWrapReq,
  input  wire txBit,
  input  wire txBitValid,
  input  wire txFrameEnd,
  output wire txBitReady,
  output reg  txData,
  output reg  txEnable,
  output reg  frontEndWrap,
  output reg  ringDriverTrue,
  output reg  ringDriverComp,
  output reg  ethernetMode,
  output reg  rxBit,
  output reg  rxBitValid,
  output reg  rxFrameEnd,
  output reg  carrierActive,
  output reg  collisionSeen
);
  // Two-stage synchronisers on every pin input
  reg [1:0] txClkSync_q;
  reg [1:0] rxClkSync_q;
  reg [1:0] rxDataSync_q;
  reg [1:0] crsSync_q;
  reg [1:0] collSync_q;
  reg       txClkPrev_q;
  reg       rxClkPrev_q;
  reg       crsPrev_q;
  reg       ethMode_q;
  // Strap synchronisers and frame gap flag
  reg [1:0] selOneSync_q;
  reg [1:0] selTwoSync_q;
  reg       txGap_q;
  reg [3:0] collCount_q;
  wire      txClkRise;
  wire      rxClkRise;
  wire      crsFall;
  wire [1:0] bufOutData;
  wire       bufOutValid;
  wire       bufOutReady;
  // Collision filter limits
  wire [31:0] collLimitWide;
  wire [31:0] collSetWide;
  wire [3:0]  collLimit;
  wire [3:0]  collSet;

  always @(posedge clk) begin
    if (rst) begin
      txClkSync_q  <= 2'h0;
      rxClkSync_q  <= 2'h0;
      rxDataSync_q <= 2'h0;
      crsSync_q    <= 2'h0;
      collSync_q   <= 2'h0;
      txClkPrev_q  <= 1'b0;
      rxClkPrev_q  <= 1'b0;
      crsPrev_q    <= 1'b0;
    end else begin
      txClkSync_q  <= {txClkSync_q[0], txBitClock};
      rxClkSync_q  <= {rxClkSync_q[0], rxBitClock};
      rxDataSync_q <= {rxDataSync_q[0], rxData};
      crsSync_q    <= {crsSync_q[0], carrierSense};
      collSync_q   <= {collSync_q[0], collisionDetect};
      txClkPrev_q  <= txClkSync_q[1];
      rxClkPrev_q  <= rxClkSync_q[1];
      crsPrev_q    <= crsSync_q[1];
    end
  end

  assign txClkRise = txClkSync_q[1] & ~txClkPrev_q;
  assign rxClkRise = rxClkSync_q[1] & ~rxClkPrev_q;
  assign crsFall   = crsPrev_q & ~crsSync_q[1];

  // Filter limits cut to the counter width on purpose;
  // the counter saturates at the limit, so four bits suffice
  assign collLimitWide = `ESMP_COLLISION_DETECT_CORE_CYCLES;
  assign collSetWide   = `ESMP_COLLISION_DETECT_CORE_CYCLES - 1;
  assign collLimit     = collLimitWide[3:0];
  assign collSet       = collSetWide[3:0];

  // Strap synchronisers carry no reset, so they are settled
  // by the time the latch below takes its last sample
  always @(posedge clk) begin
    selOneSync_q <= {selOneSync_q[0], networkSelectOne};
    selTwoSync_q <= {selTwoSync_q[0], networkSelectTwo};
  end

  // Straps sampled while reset is held, frozen after release
  always @(posedge clk) begin
    if (rst) begin
      // (RQ13) latch during reset
      // (RQ12) Ethernet select decode
      ethMode_q <= (selOneSync_q[1] == `ESMP_SEL_ONE_ETH) &&
                   (selTwoSync_q[1] == `ESMP_SEL_TWO_ETH);
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ethernetMode   <= 1'b0;
      ringDriverTrue <= `ESMP_RING_TRUE_IDLE;
      ringDriverComp <= `ESMP_RING_COMP_IDLE;
      frontEndWrap   <= 1'b0;
    end else begin
      ethernetMode   <= ethMode_q;
      // (RQ1) ring pair static
      ringDriverTrue <= `ESMP_RING_TRUE_IDLE;
      ringDriverComp <= `ESMP_RING_COMP_IDLE;
      // (RQ3) wrap request output
      frontEndWrap   <= ethMode_q & frontEndWrapReq;
    end
  end

  // Transmit path: user bits buffered, launched on link clock rise.
  // Rise is seen two core cycles late; data still settles well
  // before the front end samples on its next edge.
  // Gap cycle holds the buffer so the next frame waits
  assign bufOutReady = txClkRise & ethMode_q & ~txGap_q;

  esmp_skid_buffer #(
    .WIDTH(2)
  ) txBuffer (
    .clk      (clk),
    .rst      (rst),
    .inData   ({txFrameEnd, txBit}),
    .inValid  (txBitValid),
    .inReady  (txBitReady),
    .outData  (bufOutData),
    .outValid (bufOutValid),
    .outReady (bufOutReady)
  );

  always @(posedge clk) begin
    if (rst) begin
      txData   <= 1'b0;
      txEnable <= 1'b0;
      txGap_q  <= 1'b0;
    end else if (!ethMode_q) begin
      txData   <= 1'b0;
      txEnable <= 1'b0;
      txGap_q  <= 1'b0;
    end else if (txClkRise && txGap_q) begin
      // (RQ14) idle link cycle after frame end
      // Back-to-back frames would otherwise merge on the wire
      txData   <= 1'b0;
      txEnable <= 1'b0;
      txGap_q  <= 1'b0;
    end else if (txClkRise) begin
      // (RQ2) one bit per link clock
      // (RQ11) enable only with data
      txData   <= bufOutValid ? bufOutData[0] : 1'b0;
      txEnable <= bufOutValid;
      txGap_q  <= bufOutValid & bufOutData[1];
    end
  end

  // Receive path: data taken on rising receive clock inside carrier.
  // A frame end follows carrier fall even if the clock has stopped.
  always @(posedge clk) begin
    if (rst) begin
      rxBit         <= 1'b0;
      rxBitValid    <= 1'b0;
      rxFrameEnd    <= 1'b0;
      carrierActive <= 1'b0;
    end else begin
      carrierActive <= ethMode_q & crsSync_q[1];
      // (RQ7) sample on receive clock
      // (RQ8) carrier frames bits
      rxBitValid    <= ethMode_q & rxClkRise & crsSync_q[1];
      // Data and clock share one sync depth, so the bit is taken
      // from the same pin sample that showed the clock edge
      if (rxClkRise)
        rxBit <= rxDataSync_q[1];
      // (RQ14) frame boundary crossing
      rxFrameEnd    <= ethMode_q & crsFall;
    end
  end

  // Collision filter: short pulses dropped, heartbeat passes as a
  // plain level and never disturbs the transmit path.
  always @(posedge clk) begin
    if (rst) begin
      collCount_q   <= 4'h0;
      collisionSeen <= 1'b0;
    end else if (!collSync_q[1] || !ethMode_q) begin
      collCount_q   <= 4'h0;
      collisionSeen <= 1'b0;
    end else begin
      // (RQ9) minimum width filter
      if (collCount_q != collLimit)
        collCount_q <= collCount_q + 4'h1;
      // (RQ10) heartbeat tolerated
      collisionSeen <= (collCount_q >= collSet);
    end
  end
endmodule
`default_nettype wire

// >>> src/esmp_map.vh
`ifndef ESMP_MAP_VH
`define ESMP_MAP_VH
// Network select strap codes for Ethernet mode
`define ESMP_SEL_ONE_ETH       1'b0
`define ESMP_SEL_TWO_ETH       1'b1
// Idle levels of the unused ring driver pair
`define ESMP_RING_TRUE_IDLE    1'b1
`define ESMP_RING_COMP_IDLE    1'b0
// Link and core clock figures
`define ESMP_LINK_MHZ          10
`define ESMP_CORE_MHZ          25
`define ESMP_RX_CLK_HOLD_MAX   16
// Collision must be seen on this many link clock cycles
`define ESMP_COLLISION_DETECT_MIN_CYCLES   2
// Collision filter length in core cycles, rounded down so that a
// pulse of exactly the minimum width is still accepted
`define ESMP_COLLISION_DETECT_CORE_CYCLES \
  ((`ESMP_COLLISION_DETECT_MIN_CYCLES * `ESMP_CORE_MHZ) / `ESMP_LINK_MHZ)
`endif

// >>> src/esmp_skid_buffer.v
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer, stalls upstream only when both entries are full
module esmp_skid_buffer #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] slot0_q;
  reg [WIDTH-1:0] slot1_q;
  reg [1:0]       count_q;
  reg             ready_q;
  wire            push;
  wire            pop;
  wire [1:0]      countNext;

  // Ready registered from the next count, so the port has no
  // combinational path from the consumer side
  assign inReady  = ready_q;
  assign outValid = (count_q != 2'h0);
  assign outData  = slot0_q;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign countNext = count_q + {1'b0, push} - {1'b0, pop};

  always @(posedge clk) begin
    if (rst) begin
      ready_q <= 1'b1;
      count_q <= 2'h0;
      slot0_q <= {WIDTH{1'b0}};
      slot1_q <= {WIDTH{1'b0}};
    end else begin
      ready_q <= (countNext != 2'h2);
      case ({push, pop})
        2'b10: begin
          if (count_q == 2'h0)
            slot0_q <= inData;
          else
            slot1_q <= inData;
          count_q <= count_q + 2'h1;
        end
        2'b01: begin
          slot0_q <= slot1_q;
          count_q <= count_q - 2'h1;
        end
        2'b11: begin
          if (count_q == 2'h1)
            slot0_q <= inData;
          else begin
            slot0_q <= slot1_q;
            slot1_q <= inData;
          end
        end
        default: begin
          count_q <= count_q;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/esmp_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module esmp_port_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic txBitClock,
  input wire logic rxBitClock,
  input wire logic carrierSense,
  input wire logic collisionDetect,
  input wire logic txData,
  input wire logic txEnable,
  input wire logic frontEndWrap,
  input wire logic ringDriverTrue,
  input wire logic ringDriverComp,
  input wire logic ethernetMode,
  input wire logic rxBitValid,
  input wire logic rxFrameEnd,
  input wire logic collisionSeen
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Link clock seen high two or three samples back
  sequence txRise; $past(txBitClock, 2) || $past(txBitClock, 3); endsequence
  sequence collHeld; $past(collisionDetect, 3) && $past(collisionDetect, 4);
  endsequence
  sequence collQuiet; !collisionDetect [*5]; endsequence
  ring_pair_idle_a: assert property (
    ethernetMode |-> ringDriverTrue && !ringDriverComp) else $error("ring");
  wrap_needs_mode_a: assert property (
    frontEndWrap |-> ethernetMode) else $error("wrap outside mode");
  tx_data_timed_a: assert property (
    $changed(txData) |-> txRise) else $error("txData off clock");
  tx_enable_timed_a: assert property (
    $changed(txEnable) |-> txRise ##0 ethernetMode) else $error("txEnable");
  rx_bit_timed_a: assert property (
    rxBitValid |-> $past(carrierSense, 2) && $past(rxBitClock, 2)
    || $past(rxBitClock, 3)) else $error("rx bit timing");
  frame_end_pulse_a: assert property (
    rxFrameEnd |-> !$past(carrierSense) ##1 !rxFrameEnd) else $error("end");
  collision_detect_filter_a: assert property (
    $rose(collisionSeen) |-> collHeld) else $error("short collision");
  collision_detect_release_a: assert property (
    collQuiet |-> !collisionSeen) else $error("collision stuck");
endmodule
bind esmp_media_port esmp_port_props chk_u (.clk, .rst, .txBitClock,
  .rxBitClock, .carrierSense, .collisionDetect, .txData, .txEnable,
  .frontEndWrap, .ringDriverTrue, .ringDriverComp, .ethernetMode,
  .rxBitValid, .rxFrameEnd, .collisionSeen);
`default_nettype wire

// >>> tb/esmp_front_end_model.sv
`timescale 1ns/1ps
`default_nettype none
module esmp_front_end_model (
  input  wire logic txData,
  input  wire logic txEnable,
  output var  logic txBitClock,
  output var  logic rxBitClock,
  output var  logic rxData,
  output var  logic carrierSense,
  output var  logic collisionDetect
);
  logic txSeen[$];
  initial begin
    {txBitClock, rxBitClock, rxData, carrierSense, collisionDetect} = 5'h00;
    // Offset keeps link edges off core edges
    #7;
    forever #160 txBitClock = ~txBitClock;
  end
  always @(posedge txBitClock)
    if (txEnable === 1'b1) txSeen.push_back(txData);
  task automatic sendFrame(input logic [7:0] bits);
    #7 carrierSense = 1'b1;
    #640;
    for (int i = 0; i < 8; i++) begin
      rxData = bits[i];
      #160 rxBitClock = 1'b1;
      #160 rxBitClock = 1'b0;
    end
    carrierSense = 1'b0;
    rxData = ~rxData;
  endtask
  task automatic collide(input int ns);
    #7 collisionDetect = 1'b1;
    #(ns) collisionDetect = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, networkSelectOne = 1'b0, txBit = 1'b0;
  logic networkSelectTwo = 1'b1, frontEndWrapReq = 1'b0;
  logic txBitValid = 1'b0, txFrameEnd = 1'b0;
  wire txBitClock, rxBitClock, rxData, carrierSense, collisionDetect;
  wire txBitReady, txData, txEnable, frontEndWrap, ringDriverTrue;
  wire ringDriverComp, ethernetMode, rxBit, rxBitValid, rxFrameEnd;
  wire collisionSeen, carrierActive;
  int bad_count = 0, tests_run = 0;
  always #20 clk = ~clk;
  esmp_media_port dut_u (.clk, .rst, .networkSelectOne, .networkSelectTwo,
    .txBitClock, .rxBitClock, .rxData, .carrierSense, .collisionDetect,
    .frontEndWrapReq, .txBit, .txBitValid, .txFrameEnd, .txBitReady,
    .txData, .txEnable, .frontEndWrap, .ringDriverTrue, .ringDriverComp,
    .ethernetMode, .rxBit, .rxBitValid, .rxFrameEnd, .carrierActive,
    .collisionSeen);
  esmp_front_end_model fr_u (.txData, .txEnable, .txBitClock, .rxBitClock,
    .rxData, .carrierSense, .collisionDetect);
  task automatic check(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic resetDut(input logic selOne);
    @(posedge clk);
    rst <= 1'b1;
    networkSelectOne <= selOne;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic modeScenario();
    @(posedge clk);
    frontEndWrapReq <= 1'b1;
    repeat (4) @(negedge clk);
    check("ring", 1'b1, ringDriverTrue && !ringDriverComp);
    check("mode", 1'b1, ethernetMode);
    check("wrapOn", 1'b1, frontEndWrap);
    resetDut(1'b1);
    repeat (2) @(negedge clk);
    check("modeOff", 1'b0, ethernetMode || frontEndWrap);
    @(posedge clk);
    frontEndWrapReq <= 1'b0;
    resetDut(1'b0);
  endtask
  task automatic txScenario();
    logic [7:0] pat = 8'h4D;
    logic stall = 1'b0;
    int n;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      txBit <= pat[i];
      txFrameEnd <= (i == 7);
      txBitValid <= 1'b1;
      @(negedge clk);
      for (n = 0; n < 99 && txBitReady !== 1'b1; n++) @(negedge clk);
      if (n == 99) begin
        bad_count++;
        finish_test();
      end
      stall |= (n > 0);
      @(posedge clk);
    end
    txBitValid <= 1'b0;
    for (n = 0; n < 999 && fr_u.txSeen.size() < 8; n++) @(negedge clk);
    repeat (16) @(negedge clk);
    check("txStall", 1'b1, stall);
    check("txCount", 1'b1, fr_u.txSeen.size() == 8);
    for (int i = 0; i < 8; i++) check("txData", pat[i], fr_u.txSeen[i]);
    check("txEnable", 1'b0, txEnable);
    check("wrapOff", 1'b0, frontEndWrap);
  endtask
  task automatic rxScenario();
    logic [7:0] pat = 8'hB2;
    logic [7:0] got = 8'h00;
    int k = 0;
    fork
      fr_u.sendFrame(pat);
      for (int n = 0; n < 999 && k < 8; n++) begin
        @(negedge clk);
        if (rxBitValid === 1'b1) begin
          got[k++] = rxBit;
          check("carrierOn", 1'b1, carrierActive);
        end
      end
    join
    if (k < 8) begin
      bad_count++;
      finish_test();
    end
    for (k = 0; k < 20 && rxFrameEnd !== 1'b1; k++) @(negedge clk);
    check("rxEnd", 1'b1, rxFrameEnd);
    check("carrierOff", 1'b0, carrierActive);
    for (k = 0; k < 8; k++) check("rxBit", pat[k], got[k]);
  endtask
  task automatic collScenario();
    int n;
    fr_u.collide(200);
    for (n = 0; n < 12 && collisionSeen !== 1'b1; n++) @(negedge clk);
    check("collMin", 1'b1, collisionSeen);
    repeat (10) @(negedge clk);
    fr_u.collide(80);
    repeat (10) @(negedge clk);
    check("collShort", 1'b0, collisionSeen);
    fork
      fr_u.collide(800);
      begin
        repeat (18) @(negedge clk);
        check("collLong", 1'b1, collisionSeen);
      end
    join
    repeat (6) @(negedge clk);
    check("collDrop", 1'b0, collisionSeen);
  endtask
  initial begin
    resetDut(1'b0);
    modeScenario();
    txScenario();
    rxScenario();
    collScenario();
    finish_test();
  end
endmodule
`default_nettype wire
